// *** logic/pbsig_bridge_pins.sv ***
/*
 Pin-level signalling of a two-port bus bridge: primary error pins, request, idle parking,
 speed strap status and secondary parity generation/park, with an APB register slave.
 Assumes primary and secondary buses share pclk; forwarding logic supplies events and data.
*/
// Contract
// - Assert primary_parity_error_n on detected data parity error for received primary data.
// - Drive primary_parity_error_n high one cycle before releasing it.
// - Only pull primary_system_error_n low; never drive it high.
// - System error on address parity, posted-write data parity, or secondary system error.
// - System error on posted-write aborts, discards, or delayed-transaction master timeout.
// - Keep primary_bus_request_n deasserted at least two clocks before reasserting.
// - Park primary address, command and parity when idle and granted.
// - While primary reset low, all bus outputs float asynchronously.
// - In synchronous mode drive secondary_speed_select low.
// - Synchronous mode: 66MHz status bit 21 follows speed_strap_config.
// - Asynchronous mode: 66MHz status bit 21 follows sampled primary_speed_select.
// - Secondary data moves only when both ready signals are asserted.
// - Secondary initiator holds write data stable while its ready is asserted.
// - Park secondary address/data when idle and internal grant asserted.
// - Secondary initiator drives command in address phase, byte enables after.
// - Park secondary command/byte enables when idle and internal grant asserted.
// - Secondary parity makes address, command and parity hold even ones.
// - Secondary address parity valid one cycle after the address phase.
// - Secondary write parity valid one clock after initiator ready asserted.
// - Secondary read parity valid one clock after target ready asserted.
// - Primary parity is even and is checked for address and data errors.
`timescale 1ns/100ps
`include "pbsig_defines.svh"
module pbsig_bridge_pins import pbsig_pkg::*; (
	// Clock, enable, reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Primary bus observed
	input wire logic primary_frame_n,
	input wire logic primary_irdy_n,
	input wire logic primary_trdy_n,
	input wire logic [31:0] primary_addr_data_in,
	input wire logic [3:0] primary_cmd_byte_en_in,
	input wire logic primary_parity_in,
	input wire logic primary_bus_grant_n,
	input wire logic primary_speed_select,
	input wire logic pri_write_data_phase,
	// Primary bus driven
	output logic [31:0] primary_addr_data_out,
	output logic [3:0] primary_cmd_byte_en_out,
	output logic primary_parity_out,
	output logic primary_park_oe,
	output logic primary_parity_error_n_out,
	output logic primary_parity_error_n_oe,
	output logic primary_system_error_n_out,
	output logic primary_system_error_n_oe,
	output logic primary_bus_request_n,
	output logic primary_bus_request_n_oe,
	// Forwarding-side events and requests
	input wire logic want_primary,
	input wire pbsig_evt_s fwd_evt,
	input wire logic secondary_system_error_n,
	input wire logic speed_strap_config,
	// Secondary bus
	input wire logic secondary_idle,
	input wire logic secondary_int_grant,
	input wire logic secondary_drive_ad,
	input wire pbsig_bus_s secondary_src,
	input wire logic secondary_initiator_ready_n,
	input wire logic secondary_target_ready_n,
	output pbsig_bus_s secondary_bus_out,
	output logic secondary_ad_oe,
	output logic secondary_par_oe,
	output logic secondary_speed_select,
	output logic secondary_speed_select_oe,
	output logic secondary_data_xfer
);
	typedef struct packed {
		pbsig_req_e req;
		logic [1:0] gap;
		logic perr_on;
		logic perr_release;
		logic serr_on;
		logic addr_phase_d;
		logic wdata_phase_d;
		pbsig_bus_s pri_d;
		pbsig_bus_s sec;
		logic sec_ad_oe;
		logic sec_par_oe;
		logic [31:0] ctrl;
		logic [7:0] evt_sticky;
		logic [15:0] err_cnt;
		logic [31:0] rdata;
		logic prev_frame_n;
	} pbsig_state_s;

	pbsig_state_s st;
	pbsig_state_s next_st;
	logic sserr_lvl;
	logic m66_lvl;
	logic async_mode;
	logic cap66;
	logic pri_par_err;
	logic serr_event;
	logic sec_xfer;
	logic primary_idle;

	// Even parity across 32+4 bits
	function automatic logic pbsig_par(input logic [31:0] ad, input logic [3:0] cbe);
		pbsig_par = ^{ad, cbe};
	endfunction : pbsig_par

	function automatic logic [31:0] pbsig_stat(input logic [7:0] ev, input logic c66,
		input logic serr, input logic perr);
		pbsig_stat = {10'h000, c66, 11'h000, perr, serr, ev};
	endfunction : pbsig_stat

	pbsig_sync3 u_sync_sserr (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.pin(secondary_system_error_n),
		.level(sserr_lvl)
	);

	pbsig_sync3 u_sync_m66 (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.pin(primary_speed_select),
		.level(m66_lvl)
	);

	assign async_mode = st.ctrl[`PBSIG_CTRL_ASYNC_BIT];
	assign cap66 = async_mode ? m66_lvl : speed_strap_config;
	assign sec_xfer = !secondary_initiator_ready_n && !secondary_target_ready_n;
	assign primary_idle = primary_frame_n && primary_irdy_n;

	// Parity of the previous cycle's address or write data phase
	assign pri_par_err = (st.addr_phase_d || st.wdata_phase_d) &&
		(pbsig_par(st.pri_d.ad, st.pri_d.cbe) != primary_parity_in);
	assign serr_event = (st.addr_phase_d && pri_par_err) || (|fwd_evt) || !sserr_lvl;

	always_comb begin
		next_st = st;
		next_st.rdata = st.rdata;
		if (clk_en) begin
			// Frame is on pclk already; edge taken from raw level
			next_st.prev_frame_n = primary_frame_n;
			next_st.addr_phase_d = st.prev_frame_n && !primary_frame_n;
			next_st.wdata_phase_d = pri_write_data_phase && !primary_irdy_n && !primary_trdy_n;
			next_st.pri_d = '{ad: primary_addr_data_in, cbe: primary_cmd_byte_en_in, par: 1'b0};
			// Parity error: assert, then one cycle deasserted, then float
			next_st.perr_release = 1'b0;
			if (st.wdata_phase_d && pri_par_err) begin
				next_st.perr_on = 1'b1;
			end else if (st.perr_on) begin
				next_st.perr_on = 1'b0;
				next_st.perr_release = 1'b1;
			end
			next_st.serr_on = serr_event;
			// Request with minimum deasserted gap
			case (st.req)
				PBSIG_REQ_IDLE: begin
					if (want_primary)
						next_st.req = PBSIG_REQ_ON;
				end
				PBSIG_REQ_ON: begin
					if (!want_primary) begin
						next_st.req = PBSIG_REQ_GAP;
						next_st.gap = 2'(`PBSIG_REQ_GAP_CYC - 1);
					end
				end
				PBSIG_REQ_GAP: begin
					if (st.gap == 2'h0)
						next_st.req = PBSIG_REQ_IDLE;
					else
						next_st.gap = st.gap - 2'h1;
				end
				default: next_st.req = PBSIG_REQ_IDLE;
			endcase
			// Secondary drive: data now, parity one clock later
			next_st.sec.ad = secondary_src.ad;
			next_st.sec.cbe = secondary_src.cbe;
			next_st.sec.par = pbsig_par(st.sec.ad, st.sec.cbe);
			next_st.sec_ad_oe = secondary_drive_ad || (secondary_idle && secondary_int_grant);
			next_st.sec_par_oe = st.sec_ad_oe;
			if (secondary_idle && secondary_int_grant && !secondary_drive_ad) begin
				next_st.sec.ad = 32'h0000_0000;
				next_st.sec.cbe = 4'h0;
			end
			next_st.evt_sticky = st.evt_sticky | fwd_evt;
			if (serr_event && st.err_cnt != 16'hFFFF)
				next_st.err_cnt = st.err_cnt + 16'h0001;
			// APB access completes in its access cycle
			if (psel && penable && pwrite) begin
				case (paddr)
					`PBSIG_CTRL_OFS: next_st.ctrl = pwdata;
					`PBSIG_STAT_OFS: next_st.evt_sticky = (st.evt_sticky & ~pwdata[7:0]) | fwd_evt;
					`PBSIG_ERRCNT_OFS: next_st.err_cnt = 16'h0000;
					default: next_st.ctrl = st.ctrl;
				endcase
			end
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`PBSIG_CTRL_OFS: next_st.rdata = st.ctrl;
					`PBSIG_STAT_OFS: next_st.rdata = pbsig_stat(st.evt_sticky, cap66,
						st.serr_on, st.perr_on);
					`PBSIG_CFGSTAT_OFS: next_st.rdata = 32'(cap66) << `PBSIG_CAP66_BIT;
					`PBSIG_ERRCNT_OFS: next_st.rdata = {16'h0000, st.err_cnt};
					default: next_st.rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.req <= PBSIG_REQ_IDLE;
			st.prev_frame_n <= 1'b1;
			st.ctrl <= `PBSIG_CTRL_RESET;
		end else begin
			st <= next_st;
		end
	end

	// APB: zero wait on reads and writes
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(paddr == `PBSIG_CTRL_OFS ||
		paddr == `PBSIG_STAT_OFS || paddr == `PBSIG_CFGSTAT_OFS || paddr == `PBSIG_ERRCNT_OFS);
	assign prdata = st.rdata;

	// Bus drivers gated by reset level itself
	assign primary_park_oe = presetn && primary_idle && !primary_bus_grant_n;
	assign primary_addr_data_out = 32'h0000_0000;
	assign primary_cmd_byte_en_out = 4'h0;
	assign primary_parity_out = 1'b0;
	assign primary_parity_error_n_out = !st.perr_on;
	assign primary_parity_error_n_oe = presetn && (st.perr_on || st.perr_release);
	assign primary_system_error_n_out = 1'b0;
	assign primary_system_error_n_oe = presetn && st.serr_on;
	assign primary_bus_request_n = !(st.req == PBSIG_REQ_ON);
	assign primary_bus_request_n_oe = presetn;
	assign secondary_bus_out = st.sec;
	assign secondary_ad_oe = presetn && st.sec_ad_oe;
	assign secondary_par_oe = presetn && st.sec_par_oe;
	assign secondary_speed_select = 1'b0;
	assign secondary_speed_select_oe = presetn && !async_mode;
	assign secondary_data_xfer = sec_xfer;
endmodule : pbsig_bridge_pins

// *** logic/pbsig_defines.svh ***
/*
 Constants of the bridge pin-signalling block: register offsets, fields, reset values, timing.
 Assumes inclusion by bare name from the bridge pin module.
*/
`ifndef PBSIG_DEFINES_SVH
`define PBSIG_DEFINES_SVH
`define PBSIG_CTRL_OFS 12'h000
`define PBSIG_STAT_OFS 12'h004
`define PBSIG_CFGSTAT_OFS 12'h008
`define PBSIG_ERRCNT_OFS 12'h00C
`define PBSIG_CTRL_ASYNC_BIT 0
`define PBSIG_CTRL_STRAP66_BIT 1
`define PBSIG_CTRL_RESET 32'h0000_0000
`define PBSIG_CAP66_BIT 21
`define PBSIG_REQ_GAP_CYC 2
`define PBSIG_SERR_HOLD_CYC 1
`endif

// *** logic/pbsig_pkg.sv ***
/*
 Types of the bridge pin-signalling block.
 Assumes pbsig_defines.svh is on the include path.
*/
package pbsig_pkg;
	typedef struct packed {
		logic [31:0] ad;
		logic [3:0] cbe;
		logic par;
	} pbsig_bus_s;

	typedef struct packed {
		logic addr_par;
		logic pw_data_par;
		logic m_abort_pw;
		logic t_abort_pw;
		logic pw_discard;
		logic dw_discard;
		logic dr_discard;
		logic dt_timeout;
	} pbsig_evt_s;

	typedef enum logic [2:0] {
		PBSIG_REQ_IDLE = 3'b001,
		PBSIG_REQ_ON = 3'b010,
		PBSIG_REQ_GAP = 3'b100
	} pbsig_req_e;
endpackage : pbsig_pkg

// *** logic/pbsig_sync3.sv ***
/*
 Three-stage synchroniser for a single pin level with second/third agreement filter.
 Assumes a free-running pclk; held by clock enable.
*/
`timescale 1ns/100ps
module pbsig_sync3 (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Level
	input wire logic pin,
	output logic level
);
	typedef struct packed {
		logic [2:0] sh;
		logic lvl;
	} pbsig_sync_s;

	pbsig_sync_s st;
	pbsig_sync_s next_st;

	always_comb begin
		next_st = st;
		if (clk_en) begin
			next_st.sh = {st.sh[1:0], pin};
			if (st.sh[1] == st.sh[2])
				next_st.lvl = st.sh[2];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st <= '{sh: 3'b111, lvl: 1'b1};
		else
			st <= next_st;
	end

	assign level = st.lvl;
endmodule : pbsig_sync3

// *** verif/pbsig_bridge_pins_chk.sv ***
/*
 Port-level checker of the bridge pin block.
 Assumes binding into pbsig_bridge_pins, single pclk domain.
*/
`timescale 1ns/100ps
module pbsig_bridge_pins_chk import pbsig_pkg::*; (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Primary side
	input wire pbsig_evt_s fwd_evt,
	input wire logic primary_frame_n,
	input wire logic primary_irdy_n,
	input wire logic primary_bus_grant_n,
	input wire logic primary_park_oe,
	input wire logic [31:0] primary_addr_data_out,
	input wire logic [3:0] primary_cmd_byte_en_out,
	input wire logic primary_parity_out,
	input wire logic primary_parity_error_n_out,
	input wire logic primary_parity_error_n_oe,
	input wire logic primary_system_error_n_out,
	input wire logic primary_system_error_n_oe,
	input wire logic primary_bus_request_n,
	// Secondary side
	input wire logic secondary_initiator_ready_n,
	input wire logic secondary_target_ready_n,
	input wire logic secondary_data_xfer,
	input wire pbsig_bus_s secondary_bus_out,
	input wire logic secondary_par_oe,
	input wire logic secondary_speed_select,
	input wire logic secondary_speed_select_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_PERR_PULSE: assert property ((primary_parity_error_n_oe && !primary_parity_error_n_out)
		|=> (primary_parity_error_n_oe && primary_parity_error_n_out) ##1 !primary_parity_error_n_oe)
		else $error("parity error pin not released through one high cycle");
	AST_SERR_OD: assert property (primary_system_error_n_oe |-> !primary_system_error_n_out)
		else $error("system error pin driven high");
	AST_SERR_EVT: assert property ((|fwd_evt) |=> primary_system_error_n_oe)
		else $error("event without system error pulse");
	AST_REQ_GAP: assert property ($rose(primary_bus_request_n) |=> primary_bus_request_n)
		else $error("request reasserted too soon");
	AST_PARK: assert property ((primary_frame_n && primary_irdy_n && !primary_bus_grant_n)
		|-> primary_park_oe) else $error("idle granted bus not parked");
	AST_PPAR: assert property (primary_park_oe |->
		!(^{primary_addr_data_out, primary_cmd_byte_en_out, primary_parity_out}))
		else $error("parked primary parity odd");
	AST_SPAR: assert property (secondary_par_oe |-> secondary_bus_out.par ==
		^{$past(secondary_bus_out.ad), $past(secondary_bus_out.cbe)})
		else $error("secondary parity wrong");
	AST_XFER: assert property (secondary_data_xfer ==
		(!secondary_initiator_ready_n && !secondary_target_ready_n))
		else $error("transfer flag wrong");
	AST_SSPD: assert property (secondary_speed_select_oe |-> !secondary_speed_select)
		else $error("speed select driven high");
endmodule : pbsig_bridge_pins_chk

bind pbsig_bridge_pins pbsig_bridge_pins_chk u_chk (.*);

// *** verif/pbsig_pci_agent.sv ***
/*
 Primary bus agents: one-phase write initiator with parity, and an arbiter.
 Assumes the bench commands each write by a one-cycle go pulse.
*/
`timescale 1ns/100ps
module pbsig_pci_agent (
	// Clock, reset, commands
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire logic bad,
	input wire logic req_n,
	// Bus
	output logic frame_n,
	output logic irdy_n,
	output logic trdy_n,
	output logic [31:0] ad,
	output logic [3:0] cbe,
	output logic par,
	output logic wdp,
	output logic gnt_n
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{frame_n, irdy_n, trdy_n, gnt_n, wdp} <= 5'h1E;
			{ad, cbe, par} <= '0;
		end else begin
			{frame_n, irdy_n, trdy_n, wdp} <= {~{3{go}}, go};
			gnt_n <= req_n;
			// Released lines toggle so no stale value survives
			ad <= go ? 32'h5A3C_0F01 : ~ad;
			cbe <= go ? 4'h0 : ~cbe;
			par <= irdy_n ? ~par : (^{ad, cbe}) ^ bad;
		end
	end
endmodule : pbsig_pci_agent

// *** verif/pbsig_bridge_pins_tb_top.sv ***
/*
 Testbench of the bridge pin block: APB tasks and directed scenarios.
 Assumes the checker is bound and the agent model drives the primary bus.
*/
`timescale 1ns/100ps
`define CK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
	$display("BAD %s exp %0h got %0h", n, e, s); end end
module pbsig_bridge_pins_tb_top import pbsig_pkg::*;;
	logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q, primary_addr_data_in, primary_addr_data_out;
	logic [3:0] primary_cmd_byte_en_in, primary_cmd_byte_en_out;
	logic primary_frame_n, primary_irdy_n, primary_trdy_n, primary_parity_in, primary_bus_grant_n;
	logic primary_speed_select = 0, pri_write_data_phase, primary_parity_out, primary_park_oe;
	logic primary_parity_error_n_out, primary_parity_error_n_oe, primary_system_error_n_out;
	logic primary_system_error_n_oe, primary_bus_request_n, primary_bus_request_n_oe;
	logic want_primary = 0, secondary_system_error_n = 1, speed_strap_config = 0;
	logic secondary_idle = 1, secondary_int_grant = 0, secondary_drive_ad = 0;
	logic secondary_initiator_ready_n = 1, secondary_target_ready_n = 1, go = 0, bad = 0;
	logic secondary_ad_oe, secondary_par_oe, secondary_speed_select, secondary_speed_select_oe;
	logic secondary_data_xfer;
	pbsig_evt_s fwd_evt = '0;
	pbsig_bus_s secondary_src = '0, secondary_bus_out;
	int fail_count = 0, checks = 0, seen;
	wire [6:0] oes = {primary_park_oe, primary_parity_error_n_oe, primary_system_error_n_oe,
		primary_bus_request_n_oe, secondary_ad_oe, secondary_par_oe, secondary_speed_select_oe};

	pbsig_bridge_pins dut (.*);
	pbsig_pci_agent u_agent (.pclk, .presetn, .go, .bad, .req_n(primary_bus_request_n),
		.frame_n(primary_frame_n), .irdy_n(primary_irdy_n), .trdy_n(primary_trdy_n),
		.ad(primary_addr_data_in), .cbe(primary_cmd_byte_en_in), .par(primary_parity_in),
		.wdp(pri_write_data_phase), .gnt_n(primary_bus_grant_n));

	always #2 pclk = ~pclk;

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk) penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb

	task automatic print_verdict;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (8) @(posedge pclk);
		#1 `CK("oe_rst", 7'h0, oes)
		@(posedge pclk) presetn <= 1;
		for (int i = 0; i < 2; i++) begin
			@(posedge pclk) speed_strap_config <= i[0];
			apb(0, 12'h008, 0);
			`CK("cap66_sync", i[0], q[21])
		end
		`CK("sspd", 2'b10, {secondary_speed_select_oe, secondary_speed_select})
		apb(1, 12'h000, 1);
		for (int i = 0; i < 2; i++) begin
			@(posedge pclk) primary_speed_select <= i[0];
			repeat (6) @(posedge pclk);
			apb(0, 12'h008, 0);
			`CK("cap66_async", {1'b0, i[0]}, {secondary_speed_select_oe, q[21]})
		end
		apb(1, 12'h000, 0);
		apb(0, 12'h010, 0);
		`CK("unmapped", 33'h1_0000_0000, {err, q})
		for (int i = 0; i < 2; i++) begin
			@(posedge pclk) {bad, go} <= {i[0], 1'b1};
			@(posedge pclk) go <= 0;
			seen = 0;
			repeat (8) begin
				@(posedge pclk);
				#1 seen += (primary_parity_error_n_oe === 1'b1 && primary_parity_error_n_out === 1'b0);
			end
			`CK("perr", i, seen)
		end
		apb(1, 12'h00C, 0);
		for (int i = 0; i < 8; i++) begin
			@(posedge pclk) fwd_evt <= 8'h1 << i;
			@(posedge pclk) fwd_evt <= '0;
			#1 `CK("serr", 2'b10, {primary_system_error_n_oe, primary_system_error_n_out})
		end
		apb(0, 12'h00C, 0);
		`CK("errcnt", 32'h8, q)
		apb(1, 12'h004, 32'hFF);
		apb(0, 12'h004, 0);
		`CK("stat_clr", 8'h0, q[7:0])
		`CK("stat_bits", 3'b100, {q[21], q[9:8]})
		@(posedge pclk) secondary_system_error_n <= 0;
		seen = 0;
		repeat (8) begin
			@(posedge pclk);
			#1 seen += primary_system_error_n_oe === 1'b1;
		end
		`CK("sec_serr", 1'b1, seen > 0)
		@(posedge pclk) {secondary_system_error_n, want_primary} <= 2'b11;
		repeat (3) @(posedge pclk);
		#1 `CK("park", {2'b01, 37'h0}, {primary_bus_request_n, primary_park_oe,
			primary_addr_data_out, primary_cmd_byte_en_out, primary_parity_out})
		@(posedge pclk) want_primary <= 0;
		@(posedge pclk) want_primary <= 1;
		#1 seen = primary_bus_request_n === 1'b1;
		repeat (6) begin
			@(posedge pclk);
			#1 seen += primary_bus_request_n === 1'b1;
		end
		`CK("req_gap", 2'b10, {seen >= 2, primary_bus_request_n})
		@(posedge pclk) begin
			{secondary_int_grant, secondary_drive_ad} <= 2'b11;
			secondary_src <= {32'h8000_0001, 4'h7, 1'b0};
		end
		repeat (3) @(posedge pclk);
		#1 `CK("sec_drive", {2'b11, 36'h8000_0001_7, 1'b1}, {secondary_ad_oe, secondary_par_oe,
			secondary_bus_out})
		@(posedge pclk) secondary_drive_ad <= 0;
		repeat (2) @(posedge pclk);
		#1 `CK("sec_park", 37'h10_0000_0000, {secondary_ad_oe, secondary_bus_out.ad,
			secondary_bus_out.cbe})
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk) {secondary_initiator_ready_n, secondary_target_ready_n} <= i[1:0];
			@(posedge pclk);
			#1 `CK("xfer", i == 0, secondary_data_xfer)
		end
		@(posedge pclk) presetn <= 0;
		#1 `CK("oe_mid_rst", 7'h0, oes)
		print_verdict;
	end

	initial begin
		#20000;
		fail_count++;
		print_verdict;
	end
endmodule : pbsig_bridge_pins_tb_top
